//--- test_timer_counter.sv
// Self-checking bench for the 8/16-bit timer block
`timescale 1ns/1ps
module test_timer_counter;
   // Short names for the register offsets used below
   localparam logic [7:0] aCntLo = timer_pkg::ADDR_COUNT_LOW;
   localparam logic [7:0] aCntHi = timer_pkg::ADDR_COUNT_HIGH;
   localparam logic [7:0] aCmpA  = timer_pkg::ADDR_COMPARE_A;
   localparam logic [7:0] aCmpB  = timer_pkg::ADDR_COMPARE_B;
   localparam logic [7:0] aCtlA  = timer_pkg::ADDR_CONTROL_A;
   localparam logic [7:0] aCtlB  = timer_pkg::ADDR_CONTROL_B;
   localparam logic [7:0] aFlags = timer_pkg::ADDR_FLAGS;
   localparam logic [7:0] aMask  = timer_pkg::ADDR_MASK;
   // One table row: address, data written, value read back, response
   typedef struct packed {
      logic [7:0]  a;
      logic [31:0] d;
      logic [7:0]  e;
      logic [1:0]  r;
   } row_t;
   logic        clk = 1'b0, reset_n = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
   logic        bready = 1'b1, rready = 1'b1;   // Always ready: answers are taken at once
   logic [31:0] wdata = 32'h0, rdata, val, hiVal;
   logic [3:0]  wstrb = 4'hf, irqAck = 4'h0, timerIrq;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, resp;
   logic        pin = 1'b0, captureStrobe = 1'b0;
   int          failures = 0, nCompared = 0, cycles = 0;
   int          divs[5] = '{1, 8, 64, 256, 1024};
   // Plain read/write rows; the last address is unmapped
   row_t rows[9] = '{'{aCmpA, 32'h1a5, 8'ha5, 2'h0}, '{aCmpB, 32'h3c, 8'h3c, 2'h0},
      '{aCntLo, 32'h12, 8'h12, 2'h0}, '{aCntHi, 32'h34, 8'h34, 2'h0},
      '{aMask, 32'hf, 8'h0f, 2'h0}, '{aCtlA, 32'h7, 8'h07, 2'h0},
      '{aCtlA, 32'h0, 8'h00, 2'h0}, '{aCtlB, 32'h0, 8'h00, 2'h0},
      '{8'h20, 32'h55, 8'h00, timer_pkg::RESP_SLVERR}};

   timer_counter DUT (.clk(clk), .reset_n(reset_n), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .externalCountPin(pin), .captureStrobe(captureStrobe), .irqAck(irqAck),
      .timerIrq(timerIrq));

   // 100 MHz clock
   always #5 clk = ~clk;

   // Hang guard: the whole run needs well under 10k cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         conclude();
      end
   end

   // Verdict and end of run
   task automatic conclude();
      $display("compared %0d, failures %0d", nCompared, failures);
      if (failures == 0 && nCompared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // Compare seen against expected, four-state exact
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      nCompared++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   // Bus write: address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic awDone;
      logic wDone;
      awDone = 1'b0;
      wDone = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      forever begin
         @(posedge clk);
         if (!awDone && awready) begin
            awDone = 1'b1;
            awvalid <= 1'b0;
         end
         if (!wDone && wready) begin
            wDone = 1'b1;
            wvalid <= 1'b0;
         end
         if (bvalid) break;
      end
      r = bresp;
   endtask

   // Bus read; data and response taken at the edge that sees rvalid
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      forever begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      d = rdata;
      r = rresp;
   endtask

   task automatic w(input logic [7:0] a, input logic [31:0] d);
      wr(a, d, resp);
   endtask

   task automatic ex(input logic [7:0] a, input logic [31:0] e);
      rd(a, val, resp);
      check(val, e);
   endtask

   // Slow pin pulses; the tail leaves room for the two-flop synchroniser
   task automatic pulse(input int n);
      repeat (n) begin
         pin <= 1'b1;
         repeat (4) @(posedge clk);
         pin <= 1'b0;
         repeat (4) @(posedge clk);
      end
      repeat (4) @(posedge clk);
   endtask

   initial begin
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      // Everything starts at zero, timer stopped
      for (int i = 0; i < 8; i++) ex(8'(i * 4), 32'h0);
      check({28'h0, timerIrq}, 32'h0);
      // Table of plain accesses, unmapped one refused
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d, resp);
         check({30'h0, resp}, {30'h0, rows[i].r});
         rd(rows[i].a, val, resp);
         check(val, {24'h0, rows[i].e});
         check({30'h0, resp}, {30'h0, rows[i].r});
      end
      // Normal 8-bit wrap on pin rising edges, overflow only set by hardware
      w(aMask, 32'h1);
      w(aCntLo, 32'hfd);
      w(aCtlB, 32'h7);
      pulse(3);
      ex(aCntLo, 32'h00);
      ex(aFlags, 32'h1);
      check({28'h0, timerIrq}, 32'h1);
      pulse(1);
      ex(aFlags, 32'h1);
      ex(aCntHi, 32'h34);
      irqAck <= 4'h1;
      @(posedge clk);
      irqAck <= 4'h0;
      ex(aFlags, 32'h0);
      check({28'h0, timerIrq}, 32'h0);
      // Stopped timer ignores pin edges
      w(aCtlB, 32'h0);
      pulse(2);
      ex(aCntLo, 32'h01);
      // Both compare units in 8-bit mode, flag one tick after the match
      w(aCmpA, 32'h5);
      w(aCmpB, 32'h7);
      w(aCntLo, 32'h3);
      w(aCtlB, 32'h7);
      pulse(2);
      ex(aFlags, 32'h0);
      pulse(1);
      ex(aFlags, 32'h2);
      pulse(2);
      ex(aFlags, 32'h6);
      check({28'h0, timerIrq}, 32'h0);
      // Counter write onto the compare value blocks that match
      w(aFlags, 32'hf);
      w(aCntLo, 32'h5);
      pulse(1);
      ex(aFlags, 32'h0);
      ex(aCntLo, 32'h6);
      // Counter write while ticking every clock: the very next tick's match is blocked
      w(aCtlB, 32'h1);
      w(aCntLo, 32'h5);
      rd(aFlags, val, resp);
      w(aCtlB, 32'h7);
      check({31'h0, val[1]}, 32'h0);
      // Clear-on-match with top below count: runs through max first
      w(aCtlA, 32'h1);
      w(aCmpA, 32'h2);
      w(aCntLo, 32'hfe);
      w(aFlags, 32'hf);
      pulse(5);
      ex(aCntLo, 32'h0);
      ex(aFlags, 32'h3);
      // 16-bit wrap, then one compare unit on the B:A pair
      w(aCtlA, 32'h2);
      w(aCntHi, 32'hff);
      w(aCntLo, 32'hfe);
      w(aCmpA, 32'hff);
      w(aCmpB, 32'h0);
      w(aFlags, 32'hf);
      pulse(2);
      ex(aCntHi, 32'h0);
      ex(aFlags, 32'h1);
      w(aCntLo, 32'hfe);
      w(aFlags, 32'hf);
      pulse(3);
      ex(aCntHi, 32'h1);
      ex(aFlags, 32'h2);
      // 8-bit capture copies the count and raises its flag
      w(aCtlB, 32'h0);
      w(aCtlA, 32'h4);
      w(aCntLo, 32'h42);
      w(aFlags, 32'hf);
      captureStrobe <= 1'b1;
      @(posedge clk);
      captureStrobe <= 1'b0;
      repeat (2) @(posedge clk);
      ex(aCmpA, 32'h42);
      ex(aFlags, 32'h8);
      // 16-bit capture also copies the high byte into compare B
      w(aCtlA, 32'h6);
      captureStrobe <= 1'b1;
      @(posedge clk);
      captureStrobe <= 1'b0;
      @(posedge clk);
      ex(aCmpB, 32'h1);
      // Falling pin edges count too
      w(aCtlB, 32'h6);
      pulse(2);
      ex(aCntLo, 32'h44);
      // Prescaler taps in 16-bit mode: ticks over a fixed window
      w(aCtlB, 32'h0);
      w(aCtlA, 32'h2);
      for (int i = 0; i < 5; i++) begin
         w(aCntLo, 32'h0);
         w(aCntHi, 32'h0);
         w(aCtlB, 32'(i + 1));
         repeat (1100) @(posedge clk);
         w(aCtlB, 32'h0);
         rd(aCntHi, hiVal, resp);
         rd(aCntLo, val, resp);
         val = (hiVal << 8) | val;
         check(32'(val >= 1100 / divs[i] && val <= 1110 / divs[i] + 1), 32'h1);
      end
      // Reset in mid-run brings every register back to zero
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 8; i++) ex(8'(i * 4), 32'h0);
      conclude();
   end
endmodule

//--- timer_counter.sv
// 8/16-bit up-counting timer with compare, capture flags and AXI4-Lite registers
//
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// - Count low byte, compares are 8-bit registers
// - 16-bit adds high byte; compare B:A pair
// - Four flags, each maskable, all visible
// - Bottom zero; max 0xFF or 0xFFFF
// - Top is max or compare A
// - Increment each tick, restart from bottom
// - Select zero stops; select picks source
// - Counter readable and writable any time
// - CPU counter write beats clear/increment
// - Mode decode from capture, width, clear bits
// - Compare writes take effect immediately
// - Normal 8-bit wraps, overflow on zero
// - Hardware only sets overflow, never clears
// - Clear-on-match clears counter at compare A
// - Clear-on-match raises compare A flag
// - Compare below count misses until wrap
// - Clear-on-match still flags overflow at max
// - 16-bit wraps, overflow on zero
// - Two compare units 8-bit, one 16-bit
// - Select codes: /1,/8,/64,/256,/1024, pin edges
// - Flag set next tick; 16-bit only A
// - Counter write blocks next-tick compare match
module timer_counter (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   input  wire logic        externalCountPin,
   input  wire logic        captureStrobe,
   input  wire logic [3:0]  irqAck,
   output logic [3:0]       timerIrq
);
   // Bus state: held write address/data, write response and read data
   logic                    awHeld_reg;      // Address taken, waiting
   logic                    wHeld_reg;       // Data taken, waiting
   logic [7:0]              awAddr_reg;      // Held write address
   logic [31:0]             wData_reg;       // Held write data
   logic [3:0]              wStrb_reg;       // Held byte strobes
   logic                    bValid_reg;      // Write response pending
   logic [1:0]              bResp_reg;       // Write response code
   logic                    rValid_reg;      // Read data pending
   logic [31:0]             rData_reg;       // Read data
   logic [1:0]              rResp_reg;       // Read response code
   // Timer state
   logic [7:0]              countLow_reg;    // Counter low byte
   logic [7:0]              countHigh_reg;   // Counter high byte
   logic [7:0]              compareA_reg;    // Compare A
   logic [7:0]              compareB_reg;    // Compare B
   timer_pkg::mode_ctrl_t   modeCtrl_reg;    // Mode bits
   logic [2:0]              clockSelect_reg; // Clock select field
   logic [3:0]              flags_reg;       // Sticky flags
   logic [3:0]              flags_next;      // Next flag value
   logic [3:0]              mask_reg;        // Flag mask
   logic                    blockMatch_reg;  // Suppress next-tick match
   logic [9:0]              prescale_reg;    // Free-running prescaler
   logic                    extSync1_reg;    // Pin synchroniser stage 1
   logic                    extSync2_reg;    // Pin synchroniser stage 2
   logic                    extLast_reg;     // Previous synced level
   // Decoded controls
   logic                    wrFire;          // Write performed this cycle
   logic                    wrByte0;         // Low byte lane enabled
   logic                    cpuCountWrite;   // Any counter byte write
   logic                    timerTick;       // Timer tick enable
   timer_pkg::timer_mode_t  mode;            // Decoded mode
   logic                    wide;            // 16-bit operation
   logic                    ctc;             // 8-bit clear-on-match
   logic [15:0]             count16;         // Full count
   logic                    matchA;          // Compare A unit match
   logic                    matchB;          // Compare B unit match
   logic                    atMax;           // Counter at max
   logic [3:0]              flagSet;         // Hardware set requests
   logic [3:0]              flagClr;         // Software/ack clears
   logic [31:0]             readData;        // Read mux output

   // Mode decode from capture, width and clear-on-match bits
   function automatic timer_pkg::timer_mode_t decodeMode(input timer_pkg::mode_ctrl_t c);
      if (c.captureMode) begin
         decodeMode = c.widthSelect ? timer_pkg::MODE_CAPTURE16 : timer_pkg::MODE_CAPTURE8;
      end else if (c.widthSelect) begin
         decodeMode = timer_pkg::MODE_WIDE16;
      end else if (c.clearOnMatch) begin
         decodeMode = timer_pkg::MODE_CTC8;
      end else begin
         decodeMode = timer_pkg::MODE_NORMAL8;
      end
   endfunction

   // True for the eight mapped register offsets
   function automatic logic isMapped(input logic [7:0] a);
      isMapped = (a == timer_pkg::ADDR_COUNT_LOW) || (a == timer_pkg::ADDR_COUNT_HIGH) ||
                 (a == timer_pkg::ADDR_COMPARE_A) || (a == timer_pkg::ADDR_COMPARE_B) ||
                 (a == timer_pkg::ADDR_CONTROL_A) || (a == timer_pkg::ADDR_CONTROL_B) ||
                 (a == timer_pkg::ADDR_FLAGS) || (a == timer_pkg::ADDR_MASK);
   endfunction

   assign mode    = decodeMode(modeCtrl_reg);
   assign wide    = (mode == timer_pkg::MODE_WIDE16) || (mode == timer_pkg::MODE_CAPTURE16);
   assign ctc     = (mode == timer_pkg::MODE_CTC8);
   assign count16 = {countHigh_reg, countLow_reg};
   // One 16-bit compare (B high, A low) or two 8-bit units
   assign matchA  = wide ? (count16 == {compareB_reg, compareA_reg})
                         : (countLow_reg == compareA_reg);
   assign matchB  = !wide && (countLow_reg == compareB_reg);
   assign atMax   = wide ? (count16 == timer_pkg::COUNT_MAX16)
                         : (countLow_reg == timer_pkg::COUNT_MAX8);

   // Bus handshakes; a new write waits until the response is taken
   assign awready = !awHeld_reg && !bValid_reg;
   assign wready  = !wHeld_reg && !bValid_reg;
   assign wrFire  = awHeld_reg && wHeld_reg && !bValid_reg;
   assign wrByte0 = wStrb_reg[0];
   assign bvalid  = bValid_reg;
   assign bresp   = bResp_reg;
   assign arready = !rValid_reg;
   assign rvalid  = rValid_reg;
   assign rdata   = rData_reg;
   assign rresp   = rResp_reg;
   assign cpuCountWrite = wrFire && wrByte0 &&
                          ((awAddr_reg == timer_pkg::ADDR_COUNT_LOW) ||
                           (awAddr_reg == timer_pkg::ADDR_COUNT_HIGH));

   // Write address and data are taken independently, in either order
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         awHeld_reg <= 1'b0;
         wHeld_reg  <= 1'b0;
         awAddr_reg <= 8'h00;
         wData_reg  <= 32'h0000_0000;
         wStrb_reg  <= 4'h0;
      end else begin
         if (awvalid && awready) begin
            awHeld_reg <= 1'b1;
            awAddr_reg <= awaddr;
         end else if (wrFire) begin
            awHeld_reg <= 1'b0;
         end
         if (wvalid && wready) begin
            wHeld_reg <= 1'b1;
            wData_reg <= wdata;
            wStrb_reg <= wstrb;
         end else if (wrFire) begin
            wHeld_reg <= 1'b0;
         end
      end
   end

   // Write response one cycle after both halves are held
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bValid_reg <= 1'b0;
         bResp_reg  <= timer_pkg::RESP_OKAY;
      end else if (wrFire) begin
         bValid_reg <= 1'b1;
         bResp_reg  <= isMapped(awAddr_reg) ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
      end else if (bready) begin
         bValid_reg <= 1'b0;
      end
   end

   // Read mux; bits above each register read as zero
   always_comb begin
      readData = 32'h0000_0000;
      if (araddr == timer_pkg::ADDR_COUNT_LOW) begin
         readData[7:0] = countLow_reg;
      end else if (araddr == timer_pkg::ADDR_COUNT_HIGH) begin
         readData[7:0] = countHigh_reg;
      end else if (araddr == timer_pkg::ADDR_COMPARE_A) begin
         readData[7:0] = compareA_reg;
      end else if (araddr == timer_pkg::ADDR_COMPARE_B) begin
         readData[7:0] = compareB_reg;
      end else if (araddr == timer_pkg::ADDR_CONTROL_A) begin
         readData[2:0] = modeCtrl_reg;
      end else if (araddr == timer_pkg::ADDR_CONTROL_B) begin
         readData[2:0] = clockSelect_reg;
      end else if (araddr == timer_pkg::ADDR_FLAGS) begin
         readData[3:0] = flags_reg;
      end else if (araddr == timer_pkg::ADDR_MASK) begin
         readData[3:0] = mask_reg;
      end
   end

   // Read data registered one cycle after the address is taken
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rValid_reg <= 1'b0;
         rData_reg  <= 32'h0000_0000;
         rResp_reg  <= timer_pkg::RESP_OKAY;
      end else if (arvalid && arready) begin
         rValid_reg <= 1'b1;
         rData_reg  <= readData;
         rResp_reg  <= isMapped(araddr) ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
      end else if (rready) begin
         rValid_reg <= 1'b0;
      end
   end

   // Control, clock select and mask registers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         modeCtrl_reg    <= timer_pkg::MODE_CTRL_RESET;
         clockSelect_reg <= timer_pkg::CS_STOP;
         mask_reg        <= 4'h0;
      end else if (wrFire && wrByte0) begin
         if (awAddr_reg == timer_pkg::ADDR_CONTROL_A) begin
            modeCtrl_reg <= timer_pkg::mode_ctrl_t'(wData_reg[2:0]);
         end else if (awAddr_reg == timer_pkg::ADDR_CONTROL_B) begin
            clockSelect_reg <= wData_reg[2:0];
         end else if (awAddr_reg == timer_pkg::ADDR_MASK) begin
            mask_reg <= wData_reg[3:0];
         end
      end
   end

   // Compare registers: no shadow copy, so a write acts on the next compare.
   // A capture in the same cycle as a CPU write wins so the timestamp is kept.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         compareA_reg <= 8'h00;
         compareB_reg <= 8'h00;
      end else if (modeCtrl_reg.captureMode && captureStrobe) begin
         compareA_reg <= countLow_reg;
         if (wide) begin
            compareB_reg <= countHigh_reg;
         end
      end else if (wrFire && wrByte0) begin
         if (awAddr_reg == timer_pkg::ADDR_COMPARE_A) begin
            compareA_reg <= wData_reg[7:0];
         end else if (awAddr_reg == timer_pkg::ADDR_COMPARE_B) begin
            compareB_reg <= wData_reg[7:0];
         end
      end
   end

   // Free-running prescaler and external pin synchroniser
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prescale_reg <= 10'h000;
         extSync1_reg <= 1'b0;
         extSync2_reg <= 1'b0;
         extLast_reg  <= 1'b0;
      end else begin
         prescale_reg <= prescale_reg + 10'h001;
         extSync1_reg <= externalCountPin;
         extSync2_reg <= extSync1_reg;
         extLast_reg  <= extSync2_reg;
      end
   end

   // Clock select: the prescaler runs on regardless, so the first prescaled
   // tick after enabling lands anywhere within one divider period
   always_comb begin
      case (clockSelect_reg)
         timer_pkg::CS_DIV1:     timerTick = 1'b1;
         timer_pkg::CS_DIV8:     timerTick = &(prescale_reg | ~timer_pkg::PRESC_TAP8);
         timer_pkg::CS_DIV64:    timerTick = &(prescale_reg | ~timer_pkg::PRESC_TAP64);
         timer_pkg::CS_DIV256:   timerTick = &(prescale_reg | ~timer_pkg::PRESC_TAP256);
         timer_pkg::CS_DIV1024:  timerTick = &(prescale_reg | ~timer_pkg::PRESC_TAP1024);
         timer_pkg::CS_EXT_FALL: timerTick = extLast_reg && !extSync2_reg;
         timer_pkg::CS_EXT_RISE: timerTick = !extLast_reg && extSync2_reg;
         default:                timerTick = 1'b0;
      endcase
   end

   // Counter: CPU write first, then clear-on-match, then increment
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         countLow_reg  <= timer_pkg::COUNT_BOTTOM;
         countHigh_reg <= timer_pkg::COUNT_BOTTOM;
      end else if (cpuCountWrite) begin
         if (awAddr_reg == timer_pkg::ADDR_COUNT_LOW) begin
            countLow_reg <= wData_reg[7:0];
         end else begin
            countHigh_reg <= wData_reg[7:0];
         end
      end else if (timerTick) begin
         if (ctc && matchA) begin
            // Only equality clears, so a top below the count is missed
            countLow_reg <= timer_pkg::COUNT_BOTTOM;
         end else if (wide) begin
            {countHigh_reg, countLow_reg} <= count16 + 16'h0001;
         end else begin
            countLow_reg <= countLow_reg + 8'h01;
         end
      end
   end

   // Match block: armed by any counter write, spent by the next tick
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         blockMatch_reg <= 1'b0;
      end else if (cpuCountWrite) begin
         blockMatch_reg <= 1'b1;
      end else if (timerTick) begin
         blockMatch_reg <= 1'b0;
      end
   end

   // Flag set and clear terms; a set in the clear cycle wins
   always_comb begin
      flagSet = 4'h0;
      flagSet[timer_pkg::FLAG_OVERFLOW]  = timerTick && !cpuCountWrite && atMax;
      flagSet[timer_pkg::FLAG_COMPARE_A] = timerTick && !blockMatch_reg && matchA;
      flagSet[timer_pkg::FLAG_COMPARE_B] = timerTick && !blockMatch_reg && matchB;
      flagSet[timer_pkg::FLAG_CAPTURE]   = modeCtrl_reg.captureMode && captureStrobe;
      flagClr = irqAck;
      if (wrFire && wrByte0 && (awAddr_reg == timer_pkg::ADDR_FLAGS)) begin
         flagClr = flagClr | wData_reg[3:0];
      end
      flags_next = (flags_reg & ~flagClr) | flagSet;
   end

   // Sticky flags
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         flags_reg <= 4'h0;
      end else begin
         flags_reg <= flags_next;
      end
   end

   // Per-source request lines, each gated by its mask bit
   assign timerIrq = flags_reg & mask_reg;

   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);

   property p_stopped;
      clockSelect_reg == timer_pkg::CS_STOP |-> !timerTick;
   endproperty
   a_stopped: assert property (p_stopped) else $error("tick while stopped");

   property p_cpuWins;
      cpuCountWrite && (awAddr_reg == timer_pkg::ADDR_COUNT_LOW) && timerTick
         |=> countLow_reg == $past(wData_reg[7:0]);
   endproperty
   a_cpuWins: assert property (p_cpuWins) else $error("tick beat CPU write");

   property p_wrap8;
      timerTick && !cpuCountWrite && !wide && !ctc && atMax
         |=> countLow_reg == timer_pkg::COUNT_BOTTOM && flags_reg[timer_pkg::FLAG_OVERFLOW];
   endproperty
   a_wrap8: assert property (p_wrap8) else $error("8-bit wrap wrong");

   property p_wrap16;
      timerTick && !cpuCountWrite && wide && atMax
         |=> count16 == 16'h0000 && flags_reg[timer_pkg::FLAG_OVERFLOW];
   endproperty
   a_wrap16: assert property (p_wrap16) else $error("16-bit wrap wrong");

   property p_overflowSticky;
      flags_reg[timer_pkg::FLAG_OVERFLOW] && !flagClr[timer_pkg::FLAG_OVERFLOW]
         |=> flags_reg[timer_pkg::FLAG_OVERFLOW];
   endproperty
   a_overflowSticky: assert property (p_overflowSticky) else $error("overflow lost");

   property p_ctcClear;
      timerTick && !cpuCountWrite && ctc && matchA |=> countLow_reg == timer_pkg::COUNT_BOTTOM;
   endproperty
   a_ctcClear: assert property (p_ctcClear) else $error("no clear on match");

   property p_compareAFlag;
      timerTick && !blockMatch_reg && matchA |=> flags_reg[timer_pkg::FLAG_COMPARE_A];
   endproperty
   a_compareAFlag: assert property (p_compareAFlag) else $error("compare A flag missed");

   property p_blockMatch;
      cpuCountWrite ##1 (timerTick && !cpuCountWrite && !flags_reg[timer_pkg::FLAG_COMPARE_A])
         |=> !flags_reg[timer_pkg::FLAG_COMPARE_A];
   endproperty
   a_blockMatch: assert property (p_blockMatch) else $error("match not blocked");

   property p_noCompareB16;
      wide && !flags_reg[timer_pkg::FLAG_COMPARE_B] |=> !flags_reg[timer_pkg::FLAG_COMPARE_B];
   endproperty
   a_noCompareB16: assert property (p_noCompareB16) else $error("compare B in 16-bit");

   c_wrap8: cover property (timerTick && !wide && atMax);
   c_ctcClear: cover property (timerTick && ctc && matchA && !cpuCountWrite);
   c_wrap16: cover property (timerTick && wide && atMax);
   c_capture: cover property (flagSet[timer_pkg::FLAG_CAPTURE]);
endmodule

//--- timer_pkg.sv
// Constants, register map and carrier types for the 8/16-bit timer block
package timer_pkg;
   // Register byte offsets on the AXI4-Lite bus
   localparam logic [7:0] ADDR_COUNT_LOW  = 8'h00;
   localparam logic [7:0] ADDR_COUNT_HIGH = 8'h04;
   localparam logic [7:0] ADDR_COMPARE_A  = 8'h08;
   localparam logic [7:0] ADDR_COMPARE_B  = 8'h0c;
   localparam logic [7:0] ADDR_CONTROL_A  = 8'h10;
   localparam logic [7:0] ADDR_CONTROL_B  = 8'h14;
   localparam logic [7:0] ADDR_FLAGS      = 8'h18;
   localparam logic [7:0] ADDR_MASK       = 8'h1c;
   // Flag and mask bit positions
   localparam int FLAG_OVERFLOW  = 0;
   localparam int FLAG_COMPARE_A = 1;
   localparam int FLAG_COMPARE_B = 2;
   localparam int FLAG_CAPTURE   = 3;
   localparam int FLAG_COUNT     = 4;
   // Count limits
   localparam logic [7:0]  COUNT_MAX8   = 8'hff;
   localparam logic [15:0] COUNT_MAX16  = 16'hffff;
   localparam logic [7:0]  COUNT_BOTTOM = 8'h00;
   // Clock select codes
   localparam logic [2:0] CS_STOP     = 3'h0;
   localparam logic [2:0] CS_DIV1     = 3'h1;
   localparam logic [2:0] CS_DIV8     = 3'h2;
   localparam logic [2:0] CS_DIV64    = 3'h3;
   localparam logic [2:0] CS_DIV256   = 3'h4;
   localparam logic [2:0] CS_DIV1024  = 3'h5;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   localparam logic [2:0] CS_EXT_RISE = 3'h7;
   // Prescaler tap masks: tap fires when all masked bits are ones
   localparam logic [9:0] PRESC_TAP8    = 10'h007;
   localparam logic [9:0] PRESC_TAP64   = 10'h03f;
   localparam logic [9:0] PRESC_TAP256  = 10'h0ff;
   localparam logic [9:0] PRESC_TAP1024 = 10'h3ff;
   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Mode control bits as held in control register A (bits 2..0)
   typedef struct packed {
      logic captureMode;
      logic widthSelect;
      logic clearOnMatch;
   } mode_ctrl_t;
   localparam mode_ctrl_t MODE_CTRL_RESET = '{captureMode: 1'b0, widthSelect: 1'b0,
                                              clearOnMatch: 1'b0};
   // Decoded modes of operation
   typedef enum logic [2:0] {
      MODE_NORMAL8,
      MODE_CTC8,
      MODE_WIDE16,
      MODE_CAPTURE8,
      MODE_CAPTURE16
   } timer_mode_t;
endpackage
